/* File: rtl/ldc_regs.svh */
// ldc_regs.svh: offsets, field positions, reset values and timing counts
// of the led driver control bank.
// assumes a clock of 100 mhz, an internal clock period of 80 ns and 8-bit registers.
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LDC_ADDR_BASE 8'h1b
`define LDC_ADDR_CONV0 8'h1b
`define LDC_ADDR_CONV1 8'h1c
`define LDC_ADDR_SWSIZE 8'h1f
`define LDC_ADDR_MON 8'h20
`define LDC_ADDR_FAULT 8'h21
`define LDC_ADDR_DIM0 8'h24
`define LDC_ADDR_DIM2 8'h26
`define LDC_ADDR_HRC 8'h27
`define LDC_ADDR_HRCAL 8'h28
`define LDC_ADDR_PRE 8'h29
`define LDC_ADDR_THERM 8'h2a
`define LDC_IX(a) (4'((a) - `LDC_ADDR_BASE))
// ----------------------------------------------------------------------
// reset values (registers not listed reset to zero)
// ----------------------------------------------------------------------
`define LDC_RST_CONV1 8'h90
`define LDC_RST_SWSIZE 8'he4
`define LDC_RST_MON 8'hc0
`define LDC_RST_FAULT 8'h08
// ----------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------
`define LDC_CONV_EN_BIT 0
`define LDC_UV_OFF_BIT 6
`define LDC_LED_TIMING_BIT 2
`define LDC_LED_THR_OFF 2'h3
`define LDC_ALARM_CLR_BIT 7
`define LDC_FAIL_STATUS_BIT 3
`define LDC_RREF_FILT_BIT 6
`define LDC_FLIP_BIT 2
`define LDC_INIT_ZERO_BIT 7
`define LDC_INIT_PRE_BIT 6
`define LDC_CLKDIV_BIT 5
`define LDC_SKIP_BIT 4
`define LDC_FREEZE_BIT 3
`define LDC_OT_OFF_BIT 7
`define LDC_FLAG_UV 3
`define LDC_FLAG_OT 4
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LDC_CLK_MHZ 100
`define LDC_LED_SHORT_US 50
`define LDC_LED_LONG_US 100
`define LDC_FAIL_UNIT_NS 66
`define LDC_FAIL_UNIT_CYC ((`LDC_FAIL_UNIT_NS * `LDC_CLK_MHZ) / 1000)
`define LDC_RREF_FILT_NS 1000
`define LDC_RREF_FILT_CYC ((`LDC_RREF_FILT_NS * `LDC_CLK_MHZ + 999) / 1000)
`define LDC_INT_CLK_NS 80
`define LDC_INT_DIV ((`LDC_INT_CLK_NS * `LDC_CLK_MHZ) / 1000)
`define LDC_CAL_WAIT_LAST 8'hff
`define LDC_UPD_LAST 3'h7
`endif

/* File: rtl/ldc_pkg.sv */
// ldc_pkg: types of the led driver control bank.
// assumes ldc_regs.svh supplies every number.
package ldc_pkg;
  // bank of 16 byte slots from the base offset; holes stay zero
  typedef logic [15:0][7:0] ldc_bank_t;
  // calibration sequencer
  typedef enum logic [1:0] {
    LDC_CAL_IDLE = 2'b00,
    LDC_CAL_WAIT = 2'b01,
    LDC_CAL_RUN = 2'b10
  } ldc_cal_st_t;
  // pins and analog comparator outputs, all asynchronous
  typedef struct packed {
    logic [1:0] colour_sel;
    logic pwm;
    logic [2:0] chan_on;
    logic [2:0] led_low;
    logic uv;
    logic ot;
    logic regref;
    logic headroom;
  } ldc_pins_t;
  // whole state of the top module
  typedef struct packed {
    ldc_bank_t bank;
    ldc_pins_t s1;
    ldc_pins_t s2;
    logic [1:0] sel_q;
    logic pwm_q;
    logic [2:0] dim_forced;
    logic [2:0][13:0] led_cnt;
    logic [7:0] flags;
    logic fpin;
    logic [9:0] pulse_cnt;
    logic [6:0] rf_cnt;
    logic regref_f;
    logic hr_cmp;
    logic [2:0] ch_on_q;
    logic [2:0] int_div;
    logic [2:0] cal_div;
    ldc_cal_st_t cal_st;
    logic [7:0] wait_cnt;
    logic [11:0] win_cnt;
    logic [11:0] ones;
    logic [2:0] upd_cnt;
    logic [8:0] dac;
    logic [7:0] rdata;
  } ldc_state_t;
endpackage

/* File: rtl/ldc_top.sv */
// ldc_top: control register bank of a three-channel led driver with its
// fault pin, dimmer override, headroom comparator and calibration loop.
// assumes a serial bus slave on the same clock presents byte accesses.
//
// Behaviour
// [RULE1] converter enable bit gates select and pwm
// [RULE2] positive limit code and off bit
// [RULE3] negative limit code, resets to 10h
// [RULE4] idle feedback bit resets to one
// [RULE5] switch size field resets to full size
// [RULE6] undervoltage threshold field resets to 11
// [RULE7] led fault interval 50 or 100 us
// [RULE8] led open or short flagged, 11 disables
// [RULE9] alarm clear bit clears flags, self clears
// [RULE10] mode 1xxx: fault pin follows alarms
// [RULE11] interrupt mode pulse of 2^code units
// [RULE12] nonzero override code forces channel dimmer
// [RULE13] headroom scale bit doubles maximum headroom
// [RULE14] optional 1 us filter on reference comparator
// [RULE15] polarity bit inverts headroom comparator
// [RULE16] dac start value chosen on channel turn-on
// [RULE17] calibration at full or eighth rate
// [RULE18] optional 256 tick wait before calibration
// [RULE19] update rate bit freezes dac code
// [RULE20] decimation factor 1 or 32 to 2048
// [RULE21] preload gives dac upper eight bits
// [RULE22] thermal off bit disables and clears alarm
// [RULE23] one pulse per newly raised alarm; alarms raised in the same cycle or during a pulse share that one pulse
`timescale 1ns/1ps
`default_nettype none
`include "ldc_regs.svh"
module ldc_top #(
  parameter int LED_SHORT_CYC = `LDC_LED_SHORT_US * `LDC_CLK_MHZ,
  parameter int LED_LONG_CYC = `LDC_LED_LONG_US * `LDC_CLK_MHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // byte register port from the serial bus slave
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // asynchronous pins and comparators
  input wire ldc_pkg::ldc_pins_t pins,
  // control bank and derived controls
  output var ldc_pkg::ldc_bank_t bank,
  output logic [1:0] colour_sel_out,
  output logic pwm_out,
  output logic [2:0] dim_forced,
  output logic regref_filtered,
  output logic headroom_cmp_q,
  output logic [8:0] cal_dac,
  // alarm reporting
  output logic [7:0] fault_flags,
  output logic fault_pin
);

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------

  // true for the twelve implemented offsets
  function automatic logic reg_mapped(input logic [7:0] a);
    case (a)
      `LDC_ADDR_CONV0, `LDC_ADDR_CONV1, `LDC_ADDR_SWSIZE, `LDC_ADDR_MON,
      `LDC_ADDR_FAULT, `LDC_ADDR_HRC, `LDC_ADDR_HRCAL, `LDC_ADDR_PRE,
      `LDC_ADDR_THERM: reg_mapped = 1'b1;
      default: reg_mapped = (a >= `LDC_ADDR_DIM0) && (a <= `LDC_ADDR_DIM2);
    endcase
  endfunction

  // decimation window length, 1 or 16 shifted by the code
  function automatic logic [11:0] dec_len(input logic [2:0] code);
    if (code == 3'h0) begin
      dec_len = 12'h001;
    end else begin
      dec_len = 12'(12'h010 << code); // see [RULE20]
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  ldc_pkg::ldc_state_t st_r;
  ldc_pkg::ldc_state_t st_nxt;
  logic wr_hit;
  logic [3:0] ix;
  logic alarm_clr;
  logic [7:0] evt;
  logic [7:0] new_evt;
  logic [13:0] led_lim;
  logic led_det_on;
  logic [3:0] fmode;
  logic int_tick;
  logic cal_tick;
  logic ch_rise;
  logic [11:0] win_lim;
  logic [11:0] ones_sum;
  logic [12:0] twice_ones;
  logic [12:0] win_len;
  logic [7:0] c_conv0;
  logic [7:0] c_conv1;
  logic [7:0] c_mon;
  logic [7:0] c_fault;
  logic [7:0] c_hrc;
  logic [7:0] c_hrcal;
  logic [7:0] c_pre;
  logic [7:0] c_therm;

  // register views, read from the current state only
  assign c_conv0 = st_r.bank[`LDC_IX(`LDC_ADDR_CONV0)];
  assign c_conv1 = st_r.bank[`LDC_IX(`LDC_ADDR_CONV1)];
  assign c_mon = st_r.bank[`LDC_IX(`LDC_ADDR_MON)];
  assign c_fault = st_r.bank[`LDC_IX(`LDC_ADDR_FAULT)];
  assign c_hrc = st_r.bank[`LDC_IX(`LDC_ADDR_HRC)];
  assign c_hrcal = st_r.bank[`LDC_IX(`LDC_ADDR_HRCAL)];
  assign c_pre = st_r.bank[`LDC_IX(`LDC_ADDR_PRE)];
  assign c_therm = st_r.bank[`LDC_IX(`LDC_ADDR_THERM)];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    ix = 4'(reg_addr - `LDC_ADDR_BASE);
    wr_hit = reg_wr && reg_mapped(reg_addr);
    alarm_clr = wr_hit && (reg_addr == `LDC_ADDR_FAULT) && reg_wdata[`LDC_ALARM_CLR_BIT];
    evt = 8'h00;
    new_evt = 8'h00;
    fmode = c_fault[3:0];
    led_det_on = c_mon[1:0] != `LDC_LED_THR_OFF;
    led_lim = c_mon[`LDC_LED_TIMING_BIT] ? 14'(LED_LONG_CYC - 1) :
      14'(LED_SHORT_CYC - 1); // see [RULE7]
    int_tick = st_r.int_div == 3'(`LDC_INT_DIV - 1);
    cal_tick = int_tick && (c_hrcal[`LDC_CLKDIV_BIT] || (st_r.cal_div == 3'h7)); // see [RULE17]
    ch_rise = |(st_r.s2.chan_on & ~st_r.ch_on_q);
    win_lim = dec_len(c_hrcal[2:0]) - 12'h001;
    ones_sum = st_r.ones + {11'h000, st_r.hr_cmp};
    twice_ones = {ones_sum, 1'b0};
    win_len = {1'b0, win_lim} + 13'h0001;

    // two-stage synchroniser for every pin and comparator
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;

    // register writes; fields keep their reset values until written
    if (wr_hit) begin
      st_nxt.bank[ix] = reg_wdata; // see [RULE2] [RULE3] [RULE5] [RULE6] [RULE13]
      if (reg_addr == `LDC_ADDR_FAULT) begin
        st_nxt.bank[ix][`LDC_ALARM_CLR_BIT] = 1'b0; // see [RULE9]
      end
    end
    // reads answer one cycle later, unmapped offsets read zero
    if (reg_rd) begin
      st_nxt.rdata = reg_mapped(reg_addr) ? st_r.bank[ix] : 8'h00;
    end

    // select and pwm are held while the converter is off
    if (c_conv0[`LDC_CONV_EN_BIT]) begin
      st_nxt.sel_q = st_r.s2.colour_sel; // see [RULE1]
      st_nxt.pwm_q = st_r.s2.pwm;
    end

    // per-channel override flag and led fault qualification
    for (int c = 0; c < 3; c++) begin
      st_nxt.dim_forced[c] = |st_r.bank[`LDC_IX(`LDC_ADDR_DIM0) + 4'(c)]; // see [RULE12]
      if (led_det_on && st_r.s2.chan_on[c] && st_r.s2.led_low[c]) begin
        if (st_r.led_cnt[c] == led_lim) begin
          evt[c] = 1'b1; // see [RULE8]
        end else begin
          st_nxt.led_cnt[c] = st_r.led_cnt[c] + 14'h0001;
        end
      end else begin
        st_nxt.led_cnt[c] = 14'h0000;
      end
    end
    evt[`LDC_FLAG_UV] = st_r.s2.uv && !c_conv1[`LDC_UV_OFF_BIT];
    evt[`LDC_FLAG_OT] = st_r.s2.ot && !c_therm[`LDC_OT_OFF_BIT]; // see [RULE22]
    new_evt = evt & ~st_r.flags;

    // sticky flags: a set in the clearing cycle survives the clear
    st_nxt.flags = (alarm_clr ? 8'h00 : st_r.flags) | evt; // see [RULE9]
    if (c_therm[`LDC_OT_OFF_BIT]) begin
      st_nxt.flags[`LDC_FLAG_OT] = 1'b0; // see [RULE22]
    end

    // fault pin: level in status mode, stretched pulse otherwise
    if (fmode[3]) begin
      st_nxt.fpin = |st_r.flags; // see [RULE10]
      st_nxt.pulse_cnt = 10'h000;
    end else if (st_r.fpin) begin
      // events during a pulse are not queued; the flags keep them
      if (st_r.pulse_cnt == 10'h000) begin
        st_nxt.fpin = 1'b0;
      end else begin
        st_nxt.pulse_cnt = st_r.pulse_cnt - 10'h001; // see [RULE11]
      end
    end else if (|new_evt) begin
      st_nxt.fpin = 1'b1; // see [RULE23]
      st_nxt.pulse_cnt = 10'((`LDC_FAIL_UNIT_CYC << fmode[2:0]) - 1); // see [RULE11]
    end

    // reference comparator, optionally held off until stable
    if (!c_hrc[`LDC_RREF_FILT_BIT]) begin
      st_nxt.regref_f = st_r.s2.regref;
      st_nxt.rf_cnt = 7'h00;
    end else if (st_r.s2.regref == st_r.regref_f) begin
      st_nxt.rf_cnt = 7'h00;
    end else if (st_r.rf_cnt == 7'(`LDC_RREF_FILT_CYC - 1)) begin
      st_nxt.regref_f = st_r.s2.regref; // see [RULE14]
      st_nxt.rf_cnt = 7'h00;
    end else begin
      st_nxt.rf_cnt = st_r.rf_cnt + 7'h01;
    end
    st_nxt.hr_cmp = st_r.s2.headroom ^ c_hrc[`LDC_FLIP_BIT]; // see [RULE15]

    // internal clock and its divide-by-eight for calibration
    st_nxt.int_div = int_tick ? 3'h0 : st_r.int_div + 3'h1;
    if (int_tick) begin
      st_nxt.cal_div = st_r.cal_div + 3'h1;
    end
    st_nxt.ch_on_q = st_r.s2.chan_on;

    // calibration sequencer
    if (ch_rise) begin
      if (c_hrcal[`LDC_INIT_ZERO_BIT]) begin
        st_nxt.dac = 9'h000; // see [RULE16]
      end else if (c_hrcal[`LDC_INIT_PRE_BIT]) begin
        st_nxt.dac = {c_pre, 1'b0}; // see [RULE16] [RULE21]
      end
      st_nxt.cal_st = c_hrcal[`LDC_SKIP_BIT] ? ldc_pkg::LDC_CAL_RUN :
        ldc_pkg::LDC_CAL_WAIT; // see [RULE18]
      st_nxt.wait_cnt = 8'h00;
      st_nxt.win_cnt = 12'h000;
      st_nxt.ones = 12'h000;
      st_nxt.upd_cnt = 3'h0;
    end else if (st_r.s2.chan_on == 3'h0) begin
      st_nxt.cal_st = ldc_pkg::LDC_CAL_IDLE;
    end else begin
      unique case (st_r.cal_st)
        ldc_pkg::LDC_CAL_IDLE: begin
          st_nxt.cal_st = ldc_pkg::LDC_CAL_IDLE;
        end
        ldc_pkg::LDC_CAL_WAIT: begin
          if (int_tick) begin
            if (st_r.wait_cnt == `LDC_CAL_WAIT_LAST) begin
              st_nxt.cal_st = ldc_pkg::LDC_CAL_RUN; // see [RULE18]
            end else begin
              st_nxt.wait_cnt = st_r.wait_cnt + 8'h01;
            end
          end
        end
        ldc_pkg::LDC_CAL_RUN: begin
          if (cal_tick) begin
            if (st_r.win_cnt == win_lim) begin
              // window done: on every eighth window the majority of comparator samples steers the dac
              st_nxt.win_cnt = 12'h000; // see [RULE20]
              st_nxt.ones = 12'h000;
              st_nxt.upd_cnt = st_r.upd_cnt + 3'h1;
              if (!c_hrcal[`LDC_FREEZE_BIT] && st_r.upd_cnt == `LDC_UPD_LAST) begin
                if (twice_ones > win_len && st_r.dac != 9'h1ff) begin
                  st_nxt.dac = st_r.dac + 9'h001; // see [RULE19]
                end else if (twice_ones < win_len && st_r.dac != 9'h000) begin
                  st_nxt.dac = st_r.dac - 9'h001;
                end
              end
            end else begin
              st_nxt.win_cnt = st_r.win_cnt + 12'h001;
              st_nxt.ones = ones_sum;
            end
          end
        end
        default: begin
          st_nxt.cal_st = ldc_pkg::LDC_CAL_IDLE;
        end
      endcase
    end

    // synchronous reset loads the documented defaults
    if (rst) begin
      st_nxt = '0;
      st_nxt.cal_st = ldc_pkg::LDC_CAL_IDLE;
      st_nxt.bank[`LDC_IX(`LDC_ADDR_CONV1)] = `LDC_RST_CONV1; // see [RULE3] [RULE4]
      st_nxt.bank[`LDC_IX(`LDC_ADDR_SWSIZE)] = `LDC_RST_SWSIZE; // see [RULE5]
      st_nxt.bank[`LDC_IX(`LDC_ADDR_MON)] = `LDC_RST_MON; // see [RULE6]
      st_nxt.bank[`LDC_IX(`LDC_ADDR_FAULT)] = `LDC_RST_FAULT; // see [RULE10]
    end
  end

  // single state register
  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign bank = st_r.bank;
  assign colour_sel_out = st_r.sel_q;
  assign pwm_out = st_r.pwm_q;
  assign dim_forced = st_r.dim_forced;
  assign regref_filtered = st_r.regref_f;
  assign headroom_cmp_q = st_r.hr_cmp;
  assign cal_dac = st_r.dac;
  assign fault_flags = st_r.flags;
  assign fault_pin = st_r.fpin;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_gate_off;
    !c_conv0[`LDC_CONV_EN_BIT] |=> $stable(colour_sel_out) && $stable(pwm_out);
  endproperty
  a_gate_off: assert property (p_gate_off) // see [RULE1]
    else $error("select or pwm moved while converter off");

  property p_alarm_clr;
    alarm_clr && (evt == 8'h00) |=> (fault_flags == 8'h00) && !c_fault[`LDC_ALARM_CLR_BIT];
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) // see [RULE9]
    else $error("alarm clear did not empty the flags");

  property p_status;
    c_fault[`LDC_FAIL_STATUS_BIT] |=> fault_pin == |$past(fault_flags);
  endproperty
  a_status: assert property (p_status) // see [RULE10]
    else $error("fault pin does not follow alarms in status mode");

  property p_pulse1;
    !fault_pin && (fmode == 4'h0) && (new_evt != 8'h00) |=> fault_pin [*6] ##1 !fault_pin;
  endproperty
  a_pulse1: assert property (p_pulse1) // see [RULE11]
    else $error("shortest fault pulse has wrong width");

  property p_no_repeat;
    !fault_pin && !fmode[3] && (new_evt == 8'h00) |=> !fault_pin;
  endproperty
  a_no_repeat: assert property (p_no_repeat) // see [RULE23]
    else $error("fault pulse without a new alarm");

  property p_dim;
    st_r.bank[`LDC_IX(`LDC_ADDR_DIM0)] != 8'h00 |=> dim_forced[0];
  endproperty
  a_dim: assert property (p_dim) // see [RULE12]
    else $error("override code set but channel not forced");

  property p_init_zero;
    ch_rise && c_hrcal[`LDC_INIT_ZERO_BIT] |=> cal_dac == 9'h000;
  endproperty
  a_init_zero: assert property (p_init_zero) // see [RULE16]
    else $error("dac did not start from zero");

  property p_preload;
    ch_rise && (c_hrcal[7:6] == 2'b01) |=> cal_dac == {$past(c_pre), 1'b0};
  endproperty
  a_preload: assert property (p_preload) // see [RULE21]
    else $error("dac did not start from the preload");

  property p_freeze;
    c_hrcal[`LDC_FREEZE_BIT] && !ch_rise |=> $stable(cal_dac);
  endproperty
  a_freeze: assert property (p_freeze) // see [RULE19]
    else $error("dac moved while frozen");

  property p_thermal;
    c_therm[`LDC_OT_OFF_BIT] |=> !fault_flags[`LDC_FLAG_OT];
  endproperty
  a_thermal: assert property (p_thermal) // see [RULE22]
    else $error("thermal alarm set while disabled");

  property p_wait;
    ch_rise && !c_hrcal[`LDC_SKIP_BIT] |=> st_r.cal_st == ldc_pkg::LDC_CAL_WAIT;
  endproperty
  a_wait: assert property (p_wait) // see [RULE18]
    else $error("calibration skipped its start wait");

endmodule
`default_nettype wire

/* File: bench/ldc_host.sv */
// ldc_host: host side of the led driver control bank, giving byte
// register strobes and timing the fault pin.
// assumes the bank samples strobes on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module ldc_host (
  // clock
  input wire logic clock,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // alarm output
  input wire logic fault_pin
);
  // ----------------------------------------------------------------
  // idle state of the bus
  // ----------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // one write strobe; released lines are scrambled so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // one read strobe; data is taken once the sampling edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  // width of the next fault pulse in clocks, bounded on both waits
  task automatic pulse(output int n, output bit ok);
    n = 0;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge clock);
      #1 ok = (fault_pin === 1'b1);
    end
    while (ok && fault_pin === 1'b1 && n < 2000) begin
      n++;
      @(posedge clock);
      #1;
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// testbench: register, alarm, fault pin and calibration tests of ldc_top.
// assumes ldc_host for register access and short led fault intervals.
`timescale 1ns/1ps
`default_nettype none
`include "ldc_regs.svh"
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock;
  logic rst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, pwm_out, regref_filtered, headroom_cmp_q, fault_pin;
  logic [1:0] colour_sel_out;
  logic [2:0] dim_forced;
  logic [8:0] cal_dac;
  logic [7:0] fault_flags;
  ldc_pkg::ldc_pins_t pins;
  ldc_pkg::ldc_bank_t bank;
  int fail_count;
  int compares;
  int n;
  int k;
  bit ok;
  // mapped offsets, one hole and one far unmapped place
  logic [7:0] addr_tab [14] = '{8'h1b, 8'h1c, 8'h1f, 8'h20, 8'h21, 8'h24, 8'h25,
    8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h1d, 8'h40};
  logic [7:0] rst_tab [14] = '{8'h00, 8'h90, 8'he4, 8'hc0, 8'h08, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int codes [3] = '{0, 1, 7};

  ldc_top #(.LED_SHORT_CYC(8), .LED_LONG_CYC(16)) ldc_top_i (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pins(pins), .bank(bank), .colour_sel_out(colour_sel_out),
    .pwm_out(pwm_out), .dim_forced(dim_forced), .regref_filtered(regref_filtered),
    .headroom_cmp_q(headroom_cmp_q), .cal_dac(cal_dac), .fault_flags(fault_flags),
    .fault_pin(fault_pin));
  ldc_host ldc_host_i (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_pin(fault_pin));

  // 100 mhz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask

  // compares a little after the edge so the design's updates have landed
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    #1;
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bounded wait for a sticky flag; running out ends the run
  task automatic wait_flag(input int b, input int lim);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clock);
      #1 ok = (fault_flags[b] === 1'b1);
    end
    compares++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED flag %0d expected 1 seen %b", b, fault_flags[b]);
      final_report();
    end
  endtask

  // channel one turn-on with the dac value checked hold cycles later
  task automatic calib(input logic [8:0] exp, input int hold);
    cyc(1);
    pins.chan_on <= 3'b010;
    cyc(hold);
    chk("cal_dac", cal_dac, exp);
    cyc(1);
    pins.chan_on <= 3'b000;
    cyc(4);
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pins = '0;
    fail_count = 0;
    compares = 0;
    cyc(3);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      ldc_host_i.rd(addr_tab[i], rv);
      chk($sformatf("reset %h", addr_tab[i]), rv, rst_tab[i]);
    end
    chk("bank swsize", bank[`LDC_IX(`LDC_ADDR_SWSIZE)], 8'he4);
    $display("test reset values done");
    // select and pwm are frozen while the converter is off
    cyc(1);
    pins.colour_sel <= 2'b11;
    pins.pwm <= 1'b1;
    cyc(6);
    chk("colour_sel_out", colour_sel_out, 2'b00);
    chk("pwm_out", pwm_out, 1'b0);
    ldc_host_i.wr(`LDC_ADDR_CONV0, 8'h01);
    cyc(6);
    chk("colour_sel_out", colour_sel_out, 2'b11);
    chk("pwm_out", pwm_out, 1'b1);
    $display("test converter gating done");
    // readback; holes read zero and the clear bit never reads back
    for (int i = 0; i < 14; i++) begin
      ldc_host_i.wr(addr_tab[i], 8'ha5);
    end
    for (int i = 0; i < 14; i++) begin
      ldc_host_i.rd(addr_tab[i], rv);
      chk($sformatf("rdbk %h", addr_tab[i]), rv,
        (i > 11) ? 8'h00 : (addr_tab[i] == 8'h21) ? 8'h25 : 8'ha5);
    end
    chk("dim_forced", dim_forced, 3'b111);
    for (int i = 0; i < 14; i++) begin
      ldc_host_i.wr(addr_tab[i], rst_tab[i]);
    end
    ldc_host_i.wr(8'h25, 8'h01);
    cyc(2);
    chk("dim_forced", dim_forced, 3'b010);
    $display("test readback done");
    // comparator polarity and reference filter
    cyc(1);
    pins.headroom <= 1'b1;
    pins.regref <= 1'b1;
    cyc(6);
    chk("headroom_cmp_q", headroom_cmp_q, 1'b1);
    chk("regref_filtered", regref_filtered, 1'b1);
    ldc_host_i.wr(`LDC_ADDR_HRC, 8'h44);
    cyc(3);
    chk("headroom_cmp_q", headroom_cmp_q, 1'b0);
    cyc(1);
    pins.regref <= 1'b0;
    cyc(50);
    chk("regref_filtered", regref_filtered, 1'b1);
    cyc(80);
    chk("regref_filtered", regref_filtered, 1'b0);
    $display("test comparators done");
    // status mode, sticky flags and clear
    cyc(1);
    pins.uv <= 1'b1;
    wait_flag(3, 10);
    cyc(2);
    chk("fault_pin", fault_pin, 1'b1);
    cyc(1);
    pins.uv <= 1'b0;
    cyc(4);
    chk("fault_flags", fault_flags, 8'h08);
    ldc_host_i.wr(`LDC_ADDR_FAULT, 8'h88);
    cyc(2);
    chk("fault_flags", fault_flags, 8'h00);
    chk("fault_pin", fault_pin, 1'b0);
    ldc_host_i.rd(`LDC_ADDR_FAULT, rv);
    chk("fault ctrl", rv, 8'h08);
    // over-temperature disabled and cleared, then enabled again
    cyc(1);
    pins.ot <= 1'b1;
    wait_flag(4, 10);
    ldc_host_i.wr(`LDC_ADDR_THERM, 8'h80);
    cyc(10);
    chk("ot flag", fault_flags[4], 1'b0);
    ldc_host_i.wr(`LDC_ADDR_THERM, 8'h00);
    wait_flag(4, 10);
    cyc(1);
    pins.ot <= 1'b0;
    cyc(4);
    $display("test status mode done");
    // led fault with both intervals, then detection off
    for (int t = 0; t < 3; t++) begin
      ldc_host_i.wr(`LDC_ADDR_MON, (t == 2) ? 8'hc3 : 8'(8'hc0 | (t << 2)));
      ldc_host_i.wr(`LDC_ADDR_FAULT, 8'h88);
      cyc(1);
      pins.chan_on[0] <= 1'b1;
      pins.led_low[0] <= 1'b1;
      cyc(t == 1 ? 16 : 8);
      chk("led flag early", fault_flags[0], 1'b0);
      cyc(30);
      chk("led flag", fault_flags[0], t != 2);
      cyc(1);
      pins.chan_on[0] <= 1'b0;
      pins.led_low[0] <= 1'b0;
      cyc(4);
    end
    $display("test led fault done");
    // interrupt mode pulse widths, one pulse per event
    for (int i = 0; i < 3; i++) begin
      ldc_host_i.wr(`LDC_ADDR_FAULT, 8'(8'h80 | codes[i]));
      cyc(1);
      pins.uv <= 1'b1;
      ldc_host_i.pulse(n, ok);
      chk("pulse width", 16'(n), 16'(`LDC_FAIL_UNIT_CYC << codes[i]));
      k = 0;
      repeat (20) begin
        @(posedge clock);
        #1 k += (fault_pin === 1'b1);
      end
      chk("repeat pulse", 16'(k), 16'h0000);
      cyc(1);
      pins.uv <= 1'b0;
      cyc(4);
    end
    ldc_host_i.wr(`LDC_ADDR_FAULT, 8'h88);
    $display("test interrupt mode done");
    // dac from preload, kept while frozen, one step down, then zero
    // comparator reads low here, so every eighth unfrozen window steps the dac down
    ldc_host_i.wr(`LDC_ADDR_PRE, 8'h40);
    ldc_host_i.wr(`LDC_ADDR_HRCAL, 8'h58);
    calib(9'h080, 6);
    ldc_host_i.wr(`LDC_ADDR_PRE, 8'h11);
    ldc_host_i.wr(`LDC_ADDR_HRCAL, 8'h38);
    calib(9'h080, 100);
    ldc_host_i.wr(`LDC_ADDR_HRCAL, 8'h30);
    calib(9'h07f, 100);
    ldc_host_i.wr(`LDC_ADDR_HRCAL, 8'h31);
    calib(9'h07f, 100);
    ldc_host_i.wr(`LDC_ADDR_HRCAL, 8'h10);
    calib(9'h07f, 100);
    ldc_host_i.wr(`LDC_ADDR_HRCAL, 8'h98);
    calib(9'h000, 6);
    $display("test calibration done");
    final_report();
  end
endmodule
`default_nettype wire
